// ===== include/xdas_map.svh
// register offsets, field values and decode bounds for the xdata/port block
`ifndef XDAS_MAP_SVH
`define XDAS_MAP_SVH
`define XDAS_SFR_DPL0 8'h82
`define XDAS_SFR_DPH0 8'h83
`define XDAS_SFR_DPL1 8'h84
`define XDAS_SFR_DPH1 8'h85
`define XDAS_SFR_SEL 8'h86
`define XDAS_SFR_EXT0 8'h93
`define XDAS_SFR_EXT1 8'h95
`define XDAS_SFR_MTOP 8'hEA
`define XDAS_SFR_MPAGE 8'hA0
`define XDAS_RESET_BYTE 8'h00
`define XDAS_PORT_COUNT 9
`define XDAS_SRAM_LAST 24'h001FFF
`define XDAS_CLK_FIRST 24'h004000
`define XDAS_CLK_LAST 24'h0042FF
`define XDAS_INTC_FIRST 24'h004400
`define XDAS_INTC_LAST 24'h0044FF
`define XDAS_PORT_FIRST 24'h005000
`define XDAS_PORT_LAST 24'h0051FF
`define XDAS_ECC_FIRST 24'h080000
`define XDAS_ECC_LAST 24'h081FFF
`define XDAS_EXT_BIT 23
`endif

// ===== include/xdas_pkg.sv
// types for the xdata address and port sfr block
package xdas_pkg;
  typedef enum logic [5:0] {
    XDAS_RGN_NONE = 6'h01,
    XDAS_RGN_SRAM = 6'h02,
    XDAS_RGN_CLK = 6'h04,
    XDAS_RGN_INTC = 6'h08,
    XDAS_RGN_PORT = 6'h10,
    XDAS_RGN_ECC = 6'h20,
    XDAS_RGN_EXT = 6'h00
  } xdas_region_t;
  typedef enum logic [1:0] {
    XDAS_PTR_DPTR = 2'h0,
    XDAS_PTR_RI = 2'h1,
    XDAS_PTR_NONE = 2'h2
  } xdas_ptr_kind_t;
endpackage : xdas_pkg

// ===== design/xdas_fast_port.sv
// one fast port: output data, source select and pin state
module xdas_fast_port
  import xdas_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_data,
  input wire logic wr_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] hub_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] data_r,
  output logic [7:0] sel_r,
  output logic [7:0] pin_r,
  output logic [7:0] pin_out
);
`include "xdas_map.svh"
  logic [7:0] pin_meta_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      data_r <= `XDAS_RESET_BYTE;
    else if (wr_data)
      data_r <= wdata;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sel_r <= `XDAS_RESET_BYTE;
    else if (wr_sel)
      sel_r <= wdata;
  end

  // pin state, read only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= `XDAS_RESET_BYTE;
      pin_r <= `XDAS_RESET_BYTE;
    end
    else
    begin
      pin_meta_r <= pin_in;
      pin_r <= pin_meta_r; // [RQ7]
    end
  end

  // per pin source choice
  assign pin_out = (sel_r & data_r) | (~sel_r & hub_out); // [RQ6]
endmodule : xdas_fast_port

// ===== design/xdas_core.sv
// xdata address build, region decode and fast port sfrs
//
// Summary of operation
// [RQ1] the select register picks which of two data pointers serves pointer instructions.
// [RQ2] extension bytes shape the address only during external data moves.
// [RQ3] pointer moves take the top byte from that pointer's extension register.
// [RQ4] indirect byte moves take top byte from move top and next from move page.
// [RQ5] fast port registers exist only for ports 0 to 6, 12 and 15, three each.
// [RQ6] each pin is driven by the fast bit when its select bit is one, else hub bit.
// [RQ7] the pin state register is read only and shows live pin levels; pin_r here lags pin_in by two mclk cycles through pin_meta_r.
// [RQ8] port registers stay reachable through the hub too; sfrs reach a subset.
// [RQ9] external data addresses are 24 bits wide.
// [RQ10] addresses 0x000000 to 0x001FFF go to on-chip sram.
// [RQ11] the upper half of the space goes to the external memory interface.
// [RQ12] clocking, interrupt, port control and flash ecc windows are decoded.
// [RQ13] all registers are 8 bits and a write acts for the next instruction.
module xdas_core
  import xdas_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic xmove,
  input wire logic use_ri,
  input wire logic ri_sel,
  input wire logic [7:0] ri_value,
  input wire logic ptr_inc,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_value,
  output logic [15:0] active_ptr,
  output logic [23:0] xaddr,
  output logic sel_sram,
  output logic sel_clk,
  output logic sel_intc,
  output logic sel_port,
  output logic sel_ecc,
  output logic sel_ext,
  input wire logic [71:0] hub_out,
  input wire logic [71:0] pin_in,
  output logic [71:0] pin_out
);
`include "xdas_map.svh"
  localparam int NP = `XDAS_PORT_COUNT;
  // sfr base of each fast port: data, pin state, select
  localparam logic [7:0] DR_ADDR [NP] = '{8'h80, 8'h90, 8'h98, 8'hB0,
    8'hC0, 8'hC8, 8'hD8, 8'hE8, 8'hF8};
  localparam logic [7:0] PS_ADDR [NP] = '{8'h89, 8'h91, 8'h99, 8'hB1,
    8'hC1, 8'hC9, 8'hD9, 8'hE9, 8'hF9};
  localparam logic [7:0] SL_ADDR [NP] = '{8'h8A, 8'hA2, 8'h9A, 8'hB2,
    8'hC2, 8'hCA, 8'hDA, 8'hF2, 8'hFA};

  logic [7:0] select_r;
  logic [7:0] ext0_r;
  logic [7:0] ext1_r;
  logic [7:0] mtop_r;
  logic [7:0] mpage_r;
  logic [15:0] data_pointer_zero_r;
  logic [15:0] data_pointer_one_r;
  logic [7:0] pd [NP];
  logic [7:0] ps [NP];
  logic [7:0] pp [NP];
  logic [NP-1:0] pw_d;
  logic [NP-1:0] pw_s;
  xdas_region_t region;

  // fast ports, one instance each
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      assign pw_d[g] = sfr_wr && (sfr_addr == DR_ADDR[g]);
      assign pw_s[g] = sfr_wr && (sfr_addr == SL_ADDR[g]);
      xdas_fast_port u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_data(pw_d[g]),
        .wr_sel(pw_s[g]),
        .wdata(sfr_wdata),
        .hub_out(hub_out[g*8 +: 8]),
        .pin_in(pin_in[g*8 +: 8]),
        .data_r(pd[g]),
        .sel_r(ps[g]),
        .pin_r(pp[g]),
        .pin_out(pin_out[g*8 +: 8])
      ); // [RQ5] [RQ8]
    end
  endgenerate

  // select, extension, move top and move page registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      select_r <= `XDAS_RESET_BYTE;
      ext0_r <= `XDAS_RESET_BYTE;
      ext1_r <= `XDAS_RESET_BYTE;
      mtop_r <= `XDAS_RESET_BYTE;
      mpage_r <= `XDAS_RESET_BYTE;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr) // [RQ13]
        `XDAS_SFR_SEL: select_r <= sfr_wdata;
        `XDAS_SFR_EXT0: ext0_r <= sfr_wdata;
        `XDAS_SFR_EXT1: ext1_r <= sfr_wdata;
        `XDAS_SFR_MTOP: mtop_r <= sfr_wdata;
        `XDAS_SFR_MPAGE: mpage_r <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // two data pointers; increment and load act on the selected one
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_pointer_zero_r <= 16'h0000;
      data_pointer_one_r <= 16'h0000;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `XDAS_SFR_DPL0)
        data_pointer_zero_r[7:0] <= sfr_wdata;
      else if (sfr_wr && sfr_addr == `XDAS_SFR_DPH0)
        data_pointer_zero_r[15:8] <= sfr_wdata;
      else if (!select_r[0] && ptr_load)
        data_pointer_zero_r <= ptr_load_value; // [RQ1]
      else if (!select_r[0] && ptr_inc)
        data_pointer_zero_r <= data_pointer_zero_r + 16'h0001; // [RQ1]
      if (sfr_wr && sfr_addr == `XDAS_SFR_DPL1)
        data_pointer_one_r[7:0] <= sfr_wdata;
      else if (sfr_wr && sfr_addr == `XDAS_SFR_DPH1)
        data_pointer_one_r[15:8] <= sfr_wdata;
      else if (select_r[0] && ptr_load)
        data_pointer_one_r <= ptr_load_value; // [RQ1]
      else if (select_r[0] && ptr_inc)
        data_pointer_one_r <= data_pointer_one_r + 16'h0001; // [RQ1]
    end
  end

  assign active_ptr = select_r[0] ? data_pointer_one_r : data_pointer_zero_r; // [RQ1]

  // 24 bit address build
  always_comb
  begin
    xaddr = {8'h00, active_ptr};
    if (xmove && use_ri)
      xaddr = {mtop_r, mpage_r, ri_value}; // [RQ4] [RQ9]
    else if (xmove)
      xaddr = {(select_r[0] ? ext1_r : ext0_r), active_ptr}; // [RQ2] [RQ3]
  end

  // first level region decode
  always_comb
  begin
    region = XDAS_RGN_NONE;
    if (xaddr[`XDAS_EXT_BIT])
      region = XDAS_RGN_EXT; // [RQ11]
    else if (xaddr <= `XDAS_SRAM_LAST)
      region = XDAS_RGN_SRAM; // [RQ10]
    else if (xaddr >= `XDAS_CLK_FIRST && xaddr <= `XDAS_CLK_LAST)
      region = XDAS_RGN_CLK; // [RQ12]
    else if (xaddr >= `XDAS_INTC_FIRST && xaddr <= `XDAS_INTC_LAST)
      region = XDAS_RGN_INTC; // [RQ12]
    else if (xaddr >= `XDAS_PORT_FIRST && xaddr <= `XDAS_PORT_LAST)
      region = XDAS_RGN_PORT; // [RQ12]
    else if (xaddr >= `XDAS_ECC_FIRST && xaddr <= `XDAS_ECC_LAST)
      region = XDAS_RGN_ECC; // [RQ12]
  end

  assign sel_ext = xmove && (region == XDAS_RGN_EXT);
  assign sel_sram = xmove && (region == XDAS_RGN_SRAM);
  assign sel_clk = xmove && (region == XDAS_RGN_CLK);
  assign sel_intc = xmove && (region == XDAS_RGN_INTC);
  assign sel_port = xmove && (region == XDAS_RGN_PORT);
  assign sel_ecc = xmove && (region == XDAS_RGN_ECC);

  // sfr read mux
  always_comb
  begin
    sfr_rdata = 8'h00;
    sfr_hit = 1'b1;
    case (sfr_addr)
      `XDAS_SFR_SEL: sfr_rdata = select_r;
      `XDAS_SFR_EXT0: sfr_rdata = ext0_r;
      `XDAS_SFR_EXT1: sfr_rdata = ext1_r;
      `XDAS_SFR_MTOP: sfr_rdata = mtop_r;
      `XDAS_SFR_MPAGE: sfr_rdata = mpage_r;
      `XDAS_SFR_DPL0: sfr_rdata = data_pointer_zero_r[7:0];
      `XDAS_SFR_DPH0: sfr_rdata = data_pointer_zero_r[15:8];
      `XDAS_SFR_DPL1: sfr_rdata = data_pointer_one_r[7:0];
      `XDAS_SFR_DPH1: sfr_rdata = data_pointer_one_r[15:8];
      default:
      begin
        sfr_hit = 1'b0;
        for (int i = 0; i < NP; i++)
        begin
          if (sfr_addr == DR_ADDR[i])
          begin
            sfr_rdata = pd[i];
            sfr_hit = 1'b1;
          end
          if (sfr_addr == SL_ADDR[i])
          begin
            sfr_rdata = ps[i];
            sfr_hit = 1'b1;
          end
          if (sfr_addr == PS_ADDR[i])
          begin
            sfr_rdata = pp[i]; // [RQ7]
            sfr_hit = 1'b1;
          end
        end
      end
    endcase
  end
endmodule : xdas_core

// ===== verification/xdas_core_checker.sv
// port assertions for xdas_core
module xdas_core_checker
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic xmove,
  input wire logic use_ri,
  input wire logic [7:0] ri_value,
  input wire logic [15:0] active_ptr,
  input wire logic [23:0] xaddr,
  input wire logic sel_sram,
  input wire logic sel_ext,
  input wire logic [71:0] hub_out,
  input wire logic [71:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ext0_wr;
    sfr_wr && sfr_addr == 8'h93;
  endsequence
  a_write_next: assert property (
    s_ext0_wr ##1 sfr_addr == 8'h93 |-> sfr_rdata == $past(sfr_wdata))
    else $error("write lost");
  a_no_ext: assert property (!xmove |-> xaddr[23:16] == 8'h00)
    else $error("top byte outside move");
  a_ptr_low: assert property (
    xmove && !use_ri |-> xaddr[15:0] == active_ptr)
    else $error("pointer bytes");
  a_ri_low: assert property (
    xmove && use_ri |-> xaddr[7:0] == ri_value)
    else $error("indirect byte");
  a_sram_sel: assert property (
    sel_sram == (xmove && xaddr <= 24'h001FFF))
    else $error("sram select");
  a_ext_sel: assert property (sel_ext == (xmove && xaddr[23]))
    else $error("external select");
  a_pin_mux: assert property (
    sfr_addr == 8'h8A |-> ((pin_out[7:0] ^ hub_out[7:0]) & ~sfr_rdata) == 0)
    else $error("hub bit not on pin");
  a_unmapped_read: assert property (
    sfr_addr == 8'hB8 |-> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped answered");
endmodule : xdas_core_checker

// ===== verification/xdas_cpu_model.sv
// core model issuing one-cycle external data moves
module xdas_cpu_model
(
  input wire logic mclk,
  input wire logic req,
  input wire logic req_ri,
  input wire logic [7:0] req_byte,
  output logic xmove = 1'b0,
  output logic use_ri = 1'b0,
  output logic [7:0] ri_value = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle byte toggles so a stale value cannot pass
  always_ff @(posedge mclk)
  begin
    xmove <= req;
    use_ri <= req_ri;
    ri_value <= req ? req_byte : ~ri_value;
  end
endmodule : xdas_cpu_model

// ===== verification/testbench.sv
// bench for xdas_core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic req = 1'b0;
  logic req_ri = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] req_byte = 8'h00;
  logic ptr_inc = 1'b0;
  logic ptr_load = 1'b0;
  logic [15:0] ptr_load_value = 16'h0000;
  logic [15:0] active_ptr;
  logic [71:0] hub_out = {9{8'h55}};
  logic [71:0] pin_in = 72'h0;
  logic xmove, use_ri, sfr_hit, sel_sram, sel_clk, sel_intc;
  logic sel_port, sel_ecc, sel_ext;
  logic [7:0] ri_value, sfr_rdata;
  logic [23:0] xaddr;
  logic [71:0] pin_out;
  logic [7:0] top_t [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h80};
  logic [7:0] pg_t [7] = '{8'h1F, 8'h20, 8'h42, 8'h44, 8'h51, 8'h1F, 8'h00};
  logic [5:0] sel_t [7] = '{6'h20, 6'h00, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  int mismatches = 0;
  int total_checks = 0;
  initial forever #5 mclk = ~mclk;
  xdas_core u_dut (.mclk, .rst_n, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .sfr_hit, .xmove, .use_ri, .ri_sel(1'b0), .ri_value, .ptr_inc,
    .ptr_load, .ptr_load_value, .active_ptr, .xaddr,
    .sel_sram, .sel_clk, .sel_intc, .sel_port, .sel_ecc, .sel_ext, .hub_out,
    .pin_in, .pin_out);
  xdas_cpu_model u_cpu (.mclk, .req, .req_ri, .req_byte, .xmove, .use_ri,
    .ri_value);
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [23:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_addr <= a;
    #1;
    chk("sfr_rdata", sfr_rdata, e);
  endtask : rd
  task automatic pt(input logic ld, input logic [15:0] v, e);
    @(posedge mclk);
    sfr_wr <= 1'b0;
    ptr_load <= ld;
    ptr_inc <= !ld;
    ptr_load_value <= v;
    @(posedge mclk);
    ptr_load <= 1'b0;
    ptr_inc <= 1'b0;
    #1;
    chk("active_ptr", active_ptr, e);
  endtask : pt
  task automatic mv(input logic ri, input logic [7:0] b, input logic [23:0] e);
    @(posedge mclk);
    sfr_wr <= 1'b0;
    req <= 1'b1;
    req_ri <= ri;
    req_byte <= b;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      req <= 1'b0;
      #1;
      if (xmove === 1'b1)
        break;
    end
    if (xmove !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
    chk("xaddr", xaddr, e);
  endtask : mv
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h93, 8'h00);
    wr(8'h93, 8'hA5);
    rd(8'h93, 8'hA5);
    wr(8'h95, 8'h3C);
    wr(8'h83, 8'h10);
    wr(8'h86, 8'h01);
    wr(8'h85, 8'h81);
    mv(1'b0, 8'h00, 24'h3C8100);
    wr(8'h86, 8'h00);
    mv(1'b0, 8'h00, 24'hA51000);
    pt(1'b1, 16'h12FF, 16'h12FF);
    pt(1'b0, 16'h0000, 16'h1300);
    wr(8'h86, 8'h01);
    pt(1'b0, 16'h0000, 16'h8101);
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h13);
    rd(8'h84, 8'h01);
    mv(1'b0, 8'h00, 24'h3C8101);
    wr(8'h89, 8'hFF);
    rd(8'h89, 8'h00);
    foreach (sel_t[i])
    begin
      wr(8'hEA, top_t[i]);
      wr(8'hA0, pg_t[i]);
      mv(1'b1, 8'hFF, {top_t[i], pg_t[i], 8'hFF});
      chk("region", {sel_sram, sel_clk, sel_intc, sel_port, sel_ecc,
        sel_ext}, sel_t[i]);
    end
    wr(8'h8A, 8'h0F);
    wr(8'h80, 8'hFF);
    wr(8'hFA, 8'hF0);
    wr(8'hF8, 8'h00);
    rd(8'h8A, 8'h0F);
    chk("pin0", pin_out[7:0], 8'h5F);
    chk("pin15", pin_out[71:64], 8'h05);
    @(posedge mclk);
    pin_in <= {8'hC3, 56'h0, 8'h3A};
    repeat (3) @(posedge mclk);
    rd(8'h89, 8'h3A);
    rd(8'hF9, 8'hC3);
    rd(8'hB8, 8'h00);
    chk("hit", sfr_hit, 1'b0);
    conclude();
  end
endmodule : testbench
bind xdas_core xdas_core_checker u_chk (.mclk, .rst_n, .sfr_wr, .sfr_addr,
  .sfr_wdata, .sfr_rdata, .sfr_hit, .xmove, .use_ri, .ri_value, .active_ptr,
  .xaddr, .sel_sram, .sel_ext, .hub_out, .pin_out);
